//--- hdl/exec_mode_defines.vh
// Functional notes
// - compatibility option enabled selects legacy mode
// - legacy mode fetches byte every three clocks
// - fast mode fetches every clock, 1-5 clocks
// - legacy instructions take 6/12/18/24 clocks
// - legacy clock halved unless double speed
// - fast mode divider defaults to one
// - double speed and divider apply to secondary
// - polarity select high means active-high reset
// - legacy prescale select resets to 0101B
// - prescaler divides linearly by select plus one
// - fast mode prescale select resets to 0000B
// - prescaler serves timers, not timer2 baud/clkout
// - pin sampling at prescaler rate in legacy
// - timer overflow toggles pin when enabled
// - keypad flags cleared per bit, not read
// - reset port modes set by tristate option
// - port four upper pins replace dedicated pins
// - no external execution below 2000H, lock four
// - page programming only 64-byte half pages
// - signature bytes at 0000H, 0001H, 0003H
// - configuration bits default on any reset
`ifndef EXEC_MODE_DEFINES_VH
`define EXEC_MODE_DEFINES_VH
`define FETCH_CLKS_COMPAT      2'h3
`define FETCH_CLKS_FAST        2'h1
`define MCYCLE_CLKS_COMPAT     5'h06
`define PRESCALE_RESET_COMPAT  4'h5
`define PRESCALE_RESET_FAST    4'h0
`define RELOAD_RESET           8'hFF
`define RST_MIN_CLKS_COMPAT    4'hC
`define RST_MIN_CLKS_FAST      4'h2
`define EXT_EXEC_LIMIT         16'h1FFF
`define HALF_PAGE_BYTES        7'h40
`define SIG_ADDR_0             16'h0000
`define SIG_ADDR_1             16'h0001
`define SIG_ADDR_2             16'h0003
`define PORT_MODE_INPUT        2'h2
`define PORT_MODE_QUASI        2'h0
`define PORT_MODE_OPEN_DRAIN   2'h3
`endif

//--- hdl/timer_prescaler.v
`timescale 1ns/1ns
`default_nettype none
`include "exec_mode_defines.vh"
// shared timer prescaler: tick once every (select+1) clocks
module timer_prescaler (
  input  wire       mclk_i,
  input  wire       rst_i,
  input  wire [3:0] select_i,
  output reg        tick_o
);
  reg [3:0] count;

  // count up to the select value, then emit a tick
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      count  <= 4'h0;
      tick_o <= 1'b0;
    end else if (count >= select_i) begin
      count  <= 4'h0;
      tick_o <= 1'b1;
    end else begin
      count  <= count + 4'h1;
      tick_o <= 1'b0;
    end
  end
endmodule // timer_prescaler
`default_nettype wire

//--- hdl/overflow_toggle.v
`timescale 1ns/1ns
`default_nettype none
// toggles a counter pin on each overflow when enabled
module overflow_toggle (
  input  wire mclk_i,
  input  wire rst_i,
  input  wire enable_i,
  input  wire overflow_i,
  output reg  pin_o
);
  // flip the pin level per overflow pulse
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i)
      pin_o <= 1'b0;
    else if (enable_i && overflow_i)
      pin_o <= ~pin_o;
  end
endmodule // overflow_toggle
`default_nettype wire

//--- hdl/exec_mode_timing_config.v
`timescale 1ns/1ns
`default_nettype none
`include "exec_mode_defines.vh"
module exec_mode_timing_config (
  input  wire        mclk_i,
  input  wire        sys_rst_i,
  input  wire        reset_pin_i,
  input  wire        reset_polarity_select_i,
  input  wire        compat_option_i,
  input  wire        tristate_port_option_i,
  input  wire        double_speed_fuse_i,
  input  wire        lock_mode4_i,
  input  wire        secondary_oscillator_source_i,
  input  wire        cfg_we_i,
  input  wire [3:0]  timer_prescale_select_i,
  input  wire [7:0]  clock_reload_divider_i,
  input  wire        double_speed_option_i,
  input  wire [1:0]  timer_output_control_register_i,
  input  wire        timer2_baud_or_clkout_i,
  input  wire        timer0_overflow_i,
  input  wire        timer1_overflow_i,
  input  wire [7:0]  keypad_event_i,
  input  wire        keypad_clear_we_i,
  input  wire [7:0]  keypad_clear_mask_i,
  input  wire        ext_memory_enable_i,
  input  wire        ext_clock_used_i,
  input  wire [15:0] fetch_addr_i,
  input  wire        fetch_ext_i,
  input  wire [6:0]  page_len_i,
  input  wire        page_len_valid_i,
  input  wire [15:0] sig_addr_i,
  input  wire        sig_rd_i,
  input  wire [23:0] signature_i,
  output reg         fast_mode_o,
  output reg         core_reset_o,
  output reg         fetch_strobe_o,
  output reg  [4:0]  mcycle_clks_o,
  output reg         osc_tick_o,
  output reg  [3:0]  timer_prescale_select_o,
  output reg         timer_tick_o,
  output reg         timer2_tick_o,
  output reg         watchdog_tick_o,
  output reg         pin_sample_o,
  output reg         timer0_count_pin_o,
  output reg         timer1_count_pin_o,
  output reg  [7:0]  keypad_flag_register_o,
  output reg  [9:0]  port_mode_o,
  output reg  [3:0]  port_four_gpio_o,
  output reg         ext_exec_allow_o,
  output reg         page_accept_o,
  output reg         page_reject_o,
  output reg  [7:0]  sig_data_o,
  output reg         sig_valid_o
);
  // one-hot fetch sequencer states
  localparam [2:0] F_S0 = 3'b001;
  localparam [2:0] F_S1 = 3'b010;
  localparam [2:0] F_S2 = 3'b100;

  reg        pin_rst_active;
  reg        rst_sync_a;
  reg        rst_sync_b;
  reg        released;
  reg        compat;
  reg        double_speed;
  reg  [7:0] reload;
  reg  [9:0] osc_count;
  reg  [2:0] fetch_state;
  reg  [2:0] next_fetch_state;
  wire       presc_tick;
  wire       toggle0_pin;
  wire       toggle1_pin;
  wire [9:0] osc_limit;

  // last count of the oscillator divider: (256 - reload) clocks, twice that when halved
  function [9:0] divider_limit;
    input [7:0] reload_val;
    input       halve;
    begin
      divider_limit = (({2'b00, ~reload_val} + 10'h001) << halve) - 10'h001;
    end
  endfunction

  // reset pin polarity follows the select input
  always @* begin
    pin_rst_active = reset_polarity_select_i ? reset_pin_i : ~reset_pin_i;
  end

  // two-stage synchroniser on the pin reset; pulse width is the source's duty
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rst_sync_a <= 1'b1;
      rst_sync_b <= 1'b1;
    end else begin
      rst_sync_a <= pin_rst_active;
      rst_sync_b <= rst_sync_a;
    end
  end

  // mode latched once at reset release and held after
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      released     <= 1'b0;
      compat       <= 1'b1;
      fast_mode_o  <= 1'b0;
      core_reset_o <= 1'b1;
    end else begin
      core_reset_o <= rst_sync_b;
      if (rst_sync_b) begin
        released <= 1'b0;
      end else if (!released) begin
        released    <= 1'b1;
        compat      <= compat_option_i;
        fast_mode_o <= ~compat_option_i;
      end
    end
  end

  // software configuration, restored to defaults on any reset
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      timer_prescale_select_o <= `PRESCALE_RESET_COMPAT;
      reload                  <= `RELOAD_RESET;
      double_speed            <= 1'b0;
    end else if (rst_sync_b || !released) begin
      timer_prescale_select_o <= compat_option_i ? `PRESCALE_RESET_COMPAT : `PRESCALE_RESET_FAST;
      reload                  <= `RELOAD_RESET;
      double_speed            <= double_speed_fuse_i;
    end else if (cfg_we_i) begin
      timer_prescale_select_o <= timer_prescale_select_i;
      reload                  <= clock_reload_divider_i;
      double_speed            <= double_speed_option_i;
    end
  end

  // oscillator divider: halve in legacy mode unless double speed,
  // extra division by (256 - reload); same for either oscillator source
  assign osc_limit = divider_limit(reload, compat && !double_speed);

  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      osc_count  <= 10'h000;
      osc_tick_o <= 1'b0;
    end else if (osc_count >= osc_limit) begin
      osc_count  <= 10'h000;
      osc_tick_o <= 1'b1;
    end else begin
      osc_count  <= osc_count + 10'h001;
      osc_tick_o <= 1'b0;
    end
  end

  // fetch sequencer: three-state rotation in legacy, every clock in fast
  always @* begin
    case (fetch_state)
      F_S0:    next_fetch_state = compat ? F_S1 : F_S0;
      F_S1:    next_fetch_state = F_S2;
      F_S2:    next_fetch_state = F_S0;
      default: next_fetch_state = F_S0;
    endcase
  end

  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fetch_state    <= F_S0;
      fetch_strobe_o <= 1'b0;
      mcycle_clks_o  <= `MCYCLE_CLKS_COMPAT;
    end else if (core_reset_o) begin
      fetch_state    <= F_S0;
      fetch_strobe_o <= 1'b0;
      mcycle_clks_o  <= compat ? `MCYCLE_CLKS_COMPAT : 5'h01;
    end else begin
      fetch_state    <= next_fetch_state;
      fetch_strobe_o <= (next_fetch_state == F_S0);
      mcycle_clks_o  <= compat ? `MCYCLE_CLKS_COMPAT : 5'h01;
    end
  end

  timer_prescaler u_presc (
    .mclk_i   (mclk_i),
    .rst_i    (sys_rst_i),
    .select_i (timer_prescale_select_o),
    .tick_o   (presc_tick)
  );

  // prescaled ticks to timers and watchdog; timer2 bypass in baud/clkout
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      timer_tick_o    <= 1'b0;
      timer2_tick_o   <= 1'b0;
      watchdog_tick_o <= 1'b0;
    end else begin
      timer_tick_o    <= presc_tick;
      watchdog_tick_o <= presc_tick;
      timer2_tick_o   <= timer2_baud_or_clkout_i ? 1'b1 : presc_tick;
    end
  end

  // pin sampling strobe: prescaler rate in legacy, every clock in fast
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i)
      pin_sample_o <= 1'b0;
    else
      pin_sample_o <= compat ? presc_tick : 1'b1;
  end

  overflow_toggle u_toggle0 (
    .mclk_i     (mclk_i),
    .rst_i      (sys_rst_i),
    .enable_i   (timer_output_control_register_i[0]),
    .overflow_i (timer0_overflow_i),
    .pin_o      (toggle0_pin)
  );

  overflow_toggle u_toggle1 (
    .mclk_i     (mclk_i),
    .rst_i      (sys_rst_i),
    .enable_i   (timer_output_control_register_i[1]),
    .overflow_i (timer1_overflow_i),
    .pin_o      (toggle1_pin)
  );

  // counter pins registered out, so the pins come straight from flops
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      timer0_count_pin_o <= 1'b0;
      timer1_count_pin_o <= 1'b0;
    end else begin
      timer0_count_pin_o <= toggle0_pin;
      timer1_count_pin_o <= toggle1_pin;
    end
  end

  // keypad flags sticky until cleared per bit; a new event wins over its clear
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i)
      keypad_flag_register_o <= 8'h00;
    else if (core_reset_o)
      keypad_flag_register_o <= 8'h00;
    else
      keypad_flag_register_o <= keypad_event_i |
        (keypad_flag_register_o & ~(keypad_clear_we_i ? keypad_clear_mask_i : 8'h00));
  end

  // port modes loaded during core reset (two bits per port); port four stays quasi
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i)
      port_mode_o <= {`PORT_MODE_QUASI, {4{`PORT_MODE_INPUT}}};
    else if (core_reset_o)
      port_mode_o <= tristate_port_option_i ? {`PORT_MODE_QUASI, {4{`PORT_MODE_INPUT}}} :
        {`PORT_MODE_QUASI, `PORT_MODE_QUASI, `PORT_MODE_QUASI, `PORT_MODE_QUASI, `PORT_MODE_OPEN_DRAIN};
  end

  // port four upper pins free for general use unless clock or memory claims them
  // bits: latch enable, fetch strobe, two oscillator pins
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i)
      port_four_gpio_o <= 4'h0;
    else
      port_four_gpio_o <= {ext_clock_used_i ? 2'b00 : 2'b11,
                           ext_memory_enable_i ? 2'b00 : 2'b11};
  end

  // external execution guard: never inside the internal code range,
  // never at all in lock mode four
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i)
      ext_exec_allow_o <= 1'b0;
    else
      ext_exec_allow_o <= fetch_ext_i && (fetch_addr_i > `EXT_EXEC_LIMIT) && !lock_mode4_i;
  end

  // page programming verdict: only a half page is taken
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      page_accept_o <= 1'b0;
      page_reject_o <= 1'b0;
    end else begin
      page_accept_o <= page_len_valid_i && (page_len_i == `HALF_PAGE_BYTES);
      page_reject_o <= page_len_valid_i && (page_len_i != `HALF_PAGE_BYTES);
    end
  end

  // signature read: one byte per known address, zero elsewhere
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sig_data_o  <= 8'h00;
      sig_valid_o <= 1'b0;
    end else begin
      sig_valid_o      <= sig_rd_i && (sig_addr_i == `SIG_ADDR_0 || sig_addr_i == `SIG_ADDR_1 ||
                          sig_addr_i == `SIG_ADDR_2);
      case (sig_addr_i)
        `SIG_ADDR_0: sig_data_o <= signature_i[7:0];
        `SIG_ADDR_1: sig_data_o <= signature_i[15:8];
        `SIG_ADDR_2: sig_data_o <= signature_i[23:16];
        default:     sig_data_o <= 8'h00;
      endcase
    end
  end
endmodule // exec_mode_timing_config
`default_nettype wire

//--- tb/exec_mode_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module exec_mode_monitor (
  input wire logic        mclk_i,
  input wire logic        sys_rst_i,
  input wire logic        timer2_baud_or_clkout_i,
  input wire logic        timer0_overflow_i,
  input wire logic [1:0]  timer_output_control_register_i,
  input wire logic [15:0] fetch_addr_i,
  input wire logic        lock_mode4_i,
  input wire logic [6:0]  page_len_i,
  input wire logic        page_len_valid_i,
  input wire logic [15:0] sig_addr_i,
  input wire logic        sig_rd_i,
  input wire logic [23:0] signature_i,
  input wire logic        fast_mode_o,
  input wire logic        core_reset_o,
  input wire logic        fetch_strobe_o,
  input wire logic [3:0]  timer_prescale_select_o,
  input wire logic        timer_tick_o,
  input wire logic        timer2_tick_o,
  input wire logic        watchdog_tick_o,
  input wire logic        timer0_count_pin_o,
  input wire logic        ext_exec_allow_o,
  input wire logic        page_accept_o,
  input wire logic        page_reject_o,
  input wire logic        sig_valid_o,
  input wire logic [7:0]  sig_data_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  // fetch cadence per execution mode, and mode held outside reset
  chk_fetch_fast: assert property (fast_mode_o && fetch_strobe_o ##1 !core_reset_o |-> fetch_strobe_o)
    else $error("fast fetch gap");
  chk_fetch_legacy: assert property (disable iff (sys_rst_i || core_reset_o)
    !fast_mode_o && fetch_strobe_o |=> !fetch_strobe_o ##1 !fetch_strobe_o ##1 fetch_strobe_o)
    else $error("legacy fetch spacing wrong");
  chk_mode_held: assert property (!core_reset_o [*3] |-> $stable(fast_mode_o))
    else $error("mode changed outside reset");
  // shared prescaler behaviour and counter pin toggle
  chk_tick_period: assert property (disable iff (sys_rst_i || core_reset_o || timer_prescale_select_o != 4'h5)
    timer_tick_o |=> !timer_tick_o [*5] ##1 timer_tick_o)
    else $error("prescaler period not six");
  chk_watchdog_shared: assert property (watchdog_tick_o == timer_tick_o)
    else $error("watchdog tick differs");
  chk_timer2_bypass: assert property (timer2_baud_or_clkout_i |=> timer2_tick_o)
    else $error("timer2 not bypassed");
  chk_ovf_toggle: assert property (timer0_overflow_i && timer_output_control_register_i[0]
    |-> ##2 timer0_count_pin_o != $past(timer0_count_pin_o)) else $error("count pin did not toggle");
  // programming and execution limits
  chk_exec_block: assert property (fetch_addr_i <= 16'h1FFF || lock_mode4_i |=> !ext_exec_allow_o)
    else $error("external execution allowed");
  chk_page_size: assert property (page_len_valid_i |=>
    page_accept_o == ($past(page_len_i) == 7'h40) && page_reject_o == !page_accept_o) else $error("page verdict");
  chk_sig_byte: assert property (sig_rd_i && sig_addr_i == 16'h0001 |=>
    sig_valid_o && sig_data_o == $past(signature_i[15:8])) else $error("signature byte wrong");
  cover property (fast_mode_o && timer_tick_o);
  cover property (page_reject_o);
  cover property (sig_valid_o && !fast_mode_o);
endmodule // exec_mode_monitor
bind exec_mode_timing_config exec_mode_monitor u_exec_mode_monitor (.*);
`default_nettype wire

//--- tb/board_reset_source.sv
`timescale 1ns/1ns
`default_nettype none
// board reset source: holds the pin active for a set number of clocks
module board_reset_source (
  input  wire logic       mclk_i,
  input  wire logic       polarity_i,
  input  wire logic       go_i,
  input  wire logic [4:0] hold_clks_i,
  output var  logic       reset_pin_o
);
  logic [4:0] left = 5'h00;
  // count down the hold time
  always @(posedge mclk_i) begin
    if (go_i) left <= hold_clks_i;
    else if (left != 5'h00) left <= left - 5'h01;
  end
  assign reset_pin_o = (left != 5'h00) ~^ polarity_i;
endmodule // board_reset_source
`default_nettype wire

//--- tb/test_exec_mode_timing_config.sv
`timescale 1ns/1ns
`default_nettype none
module test_exec_mode_timing_config;
  logic mclk_i=0, sys_rst_i=1, reset_polarity_select_i=1, compat_option_i=0, tristate_port_option_i=0, rst_go=0;
  logic double_speed_fuse_i=0, lock_mode4_i=0, secondary_oscillator_source_i=0, cfg_we_i=0, double_speed_option_i=0;
  logic timer2_baud_or_clkout_i=0, timer0_overflow_i=0, timer1_overflow_i=0, keypad_clear_we_i=0;
  logic ext_memory_enable_i=0, ext_clock_used_i=0, fetch_ext_i=0, page_len_valid_i=0, sig_rd_i=0;
  logic [1:0] timer_output_control_register_i=2'h0;
  logic [3:0] timer_prescale_select_i=4'h0, timer_prescale_select_o, port_four_gpio_o;
  logic [4:0] rst_len=5'h02, mcycle_clks_o;
  logic [6:0] page_len_i=7'h00;
  logic [7:0] clock_reload_divider_i=8'hFF, keypad_event_i=8'h00, keypad_clear_mask_i=8'h00;
  logic [7:0] keypad_flag_register_o, sig_data_o;
  logic [15:0] fetch_addr_i=16'h0000, sig_addr_i=16'h0000;
  logic [23:0] signature_i=24'hC3A55A;
  logic reset_pin_i, fast_mode_o, core_reset_o, fetch_strobe_o, osc_tick_o, timer_tick_o, timer2_tick_o;
  logic watchdog_tick_o, pin_sample_o, timer0_count_pin_o, timer1_count_pin_o, ext_exec_allow_o;
  logic page_accept_o, page_reject_o, sig_valid_o;
  logic [9:0] port_mode_o;
  int num_errors=0, compares=0, cycles=0, pin_samples=0;
  board_reset_source u_board_reset_source (.mclk_i(mclk_i), .polarity_i(reset_polarity_select_i),
    .go_i(rst_go), .hold_clks_i(rst_len), .reset_pin_o(reset_pin_i));
  exec_mode_timing_config u_exec_mode_timing_config (.*);
  initial forever #4 mclk_i = ~mclk_i;
  // cut a hung run short
  always @(posedge mclk_i) if (++cycles == 5000) begin
    num_errors++;
    final_report();
  end
  task step(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task boot(input logic cm, input logic ts);
    compat_option_i = cm;
    tristate_port_option_i = ts;
    sys_rst_i = 1;
    step(6);
    sys_rst_i = 0;
    step(8);
  endtask
  task cfg(input logic [3:0] s, input logic [7:0] r, input logic d);
    timer_prescale_select_i = s;
    clock_reload_divider_i = r;
    double_speed_option_i = d;
    cfg_we_i = 1;
    step(1);
    cfg_we_i = 0;
    step(18);
  endtask
  task tally(input int n, output int f, output int o, output int t);
    f = 0; o = 0; t = 0;
    pin_samples = 0;
    repeat (n) begin
      f += fetch_strobe_o; o += osc_tick_o; t += timer_tick_o;
      pin_samples += pin_sample_o;
      step(1);
    end
  endtask
  task t_modes;
    int f, o, t;
    for (int cm = 0; cm < 2; cm++) begin
      boot(cm[0], cm[0]);
      chk("fast_mode", fast_mode_o, !cm[0]);
      chk("mcycle", mcycle_clks_o, cm ? 6 : 1);
      chk("prescale_reset", timer_prescale_select_o, cm ? 5 : 0);
      chk("port_mode", port_mode_o, cm ? 10'h0AA : 10'h003);
      tally(60, f, o, t);
      chk("fetches", f, cm ? 20 : 60);
      chk("osc_ticks", o, cm ? 30 : 60);
      chk("timer_ticks", t, cm ? 10 : 60);
      chk("pin_samples", pin_samples, cm ? 10 : 60);
    end
  endtask
  task t_osc;
    int f, o, t;
    secondary_oscillator_source_i = 1;
    double_speed_fuse_i = 1;
    boot(1, 0);
    tally(60, f, o, t);
    chk("osc_fuse_double", o, 60);
    cfg(4'h5, 8'hFE, 1);
    tally(60, f, o, t);
    chk("osc_reload", o, 30);
    cfg(4'h5, 8'hFF, 0);
    tally(60, f, o, t);
    chk("osc_halved", o, 30);
    double_speed_fuse_i = 0;
    secondary_oscillator_source_i = 0;
  endtask
  task t_prescale;
    int f, o, t;
    boot(0, 0);
    for (int s = 15; s >= 0; s--) begin
      cfg(s[3:0], 8'hFF, 0);
      chk("prescale_sel", timer_prescale_select_o, s);
      tally(4 * (s + 1), f, o, t);
      chk("prescale_ticks", t, 4);
    end
    cfg(4'hF, 8'hFF, 0);
    timer2_baud_or_clkout_i = 1;
    step(1);
    repeat (16) begin
      step(1);
      chk("timer2_bypass", timer2_tick_o, 1);
    end
    timer2_baud_or_clkout_i = 0;
  endtask
  task t_pin_reset;
    for (int p = 0; p < 2; p++) begin
      reset_polarity_select_i = p[0];
      boot(!p[0], 0);
      cfg(4'h3, 8'hFF, 0);
      rst_len = p ? 5'h02 : 5'h0C;
      rst_go = 1;
      step(1);
      rst_go = 0;
      step(4);
      chk("core_reset", core_reset_o, 1);
      step(16);
      chk("core_release", core_reset_o, 0);
      chk("prescale_default", timer_prescale_select_o, p ? 0 : 5);
    end
  endtask
  task t_misc;
    sig_rd_i = 1;
    for (int i = 0; i < 4; i++) begin
      sig_addr_i = i[15:0];
      step(1);
      chk("sig_valid", sig_valid_o, i != 2);
      chk("sig_data", sig_data_o, i == 2 ? 0 : signature_i >> (i == 3 ? 16 : 8 * i) & 24'hFF);
    end
    sig_rd_i = 0;
    page_len_valid_i = 1;
    for (int i = 62; i < 66; i++) begin
      page_len_i = i[6:0];
      step(1);
      chk("page_accept", page_accept_o, i == 64);
      chk("page_reject", page_reject_o, i != 64);
    end
    page_len_valid_i = 0;
    fetch_ext_i = 1;
    for (int i = 0; i < 6; i++) begin
      lock_mode4_i = i[0];
      fetch_addr_i = i < 2 ? 16'h1FFF : i < 4 ? 16'h2000 : 16'hFFFF;
      step(1);
      chk("ext_exec", ext_exec_allow_o, i > 1 && !i[0]);
    end
    keypad_event_i = 8'h81;
    step(1);
    keypad_event_i = 8'h00;
    step(3);
    chk("keypad_kept", keypad_flag_register_o, 8'h81);
    keypad_clear_mask_i = 8'h01;
    keypad_clear_we_i = 1;
    step(1);
    keypad_clear_we_i = 0;
    step(1);
    chk("keypad_clear", keypad_flag_register_o, 8'h80);
    keypad_event_i = 8'h80;
    keypad_clear_mask_i = 8'h80;
    keypad_clear_we_i = 1;
    step(1);
    keypad_event_i = 8'h00;
    keypad_clear_we_i = 0;
    step(1);
    chk("keypad_set_wins", keypad_flag_register_o, 8'h80);
    ext_memory_enable_i = 1;
    step(2);
    chk("port_four_gpio", port_four_gpio_o, 4'hC);
    ext_memory_enable_i = 0;
    ext_clock_used_i = 1;
    step(2);
    chk("port_four_gpio", port_four_gpio_o, 4'h3);
    ext_clock_used_i = 0;
    timer_output_control_register_i = 2'h1;
    timer0_overflow_i = 1;
    timer1_overflow_i = 1;
    step(3);
    timer0_overflow_i = 0;
    timer1_overflow_i = 0;
    step(3);
    chk("timer0_pin", timer0_count_pin_o, 1);
    chk("timer1_pin", timer1_count_pin_o, 0);
  endtask
  task final_report;
    if (num_errors == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // main sequence
  initial begin
    t_modes();
    t_osc();
    t_prescale();
    t_pin_reset();
    t_misc();
    final_report();
  end
endmodule // test_exec_mode_timing_config
`default_nettype wire
